//--- src/ipt_defines.svh
// Constants of the primary two-wire target port: addresses, resets, timing.
// Assumes mclk runs at 25 MHz; included by its bare name.
//
// Notes on behaviour
// RULE_01 - Address select pin low: answer only target address 0b1101000.
// RULE_02 - Address select pin high: answer only target address 0b1101001.
// RULE_03 - Only 7-bit addressing; ten-bit is neither used nor decoded.
// RULE_04 - Works at 100 kHz, 400 kHz and 1 MHz serial clock rates.
// RULE_05 - Data falling while clock high is a start; bus is then busy.
// RULE_06 - Data rising while clock high is a stop; master ends each transfer.
// RULE_07 - Every byte acked; receiver holds data low through ack high phase.
// RULE_08 - Stop right after start, with no clock toggling, is not recognised.
// RULE_09 - Write: start, address+0, register byte, data byte, stop; all acked.
// RULE_10 - Multi-byte writes advance the address, except on trap registers.
// RULE_11 - Read: write pointer, repeated start, address+1, then release data.
// RULE_12 - Master target_acknowledge each read byte for more; a nack makes device release.
// RULE_13 - Reads advance the register address after every byte sent.
// RULE_14 - Reads start at last written register address; 0x00 after reset.
// RULE_15 - Watchdog runs while device pulls data low; expiry resets the port.
// RULE_16 - Config bit sets watchdog period; at 0 master clocks above 100 kHz.
// RULE_17 - Host idles at least 2 us after a write in normal mode.
// RULE_18 - Host idles at least 450 us after a write in low-power modes.
// RULE_19 - Port is two-wire after reset; leaves it only when SPI is selected.
// RULE_20 - Unmatched address byte gets no ack; ignored until the next start.
`ifndef IPT_DEFINES_SVH
`define IPT_DEFINES_SVH

// Target addresses selected by the strap pin
`define IPT_ADDR_LOW       7'h68
`define IPT_ADDR_HIGH      7'h69
// Read start address after reset
`define IPT_START_RST      8'h00
// Bits in one byte, counted on the link side
`define IPT_BYTE_BITS      4'h8
// Reset level of the link synchronisers: pins idle high
`define IPT_SYNC_RST       6'h03
// Clock rate of mclk in kHz
`define IPT_MCLK_KHZ       25000
// Watchdog periods in microseconds
`define IPT_WDT_SHORT_US   50
`define IPT_WDT_LONG_US    40000
`define IPT_WDT_SHORT_CYC  ((`IPT_WDT_SHORT_US * `IPT_MCLK_KHZ) / 1000)
`define IPT_WDT_CNT_W      20
// Host idle times after writes, microseconds
`define IPT_IDLE_NORMAL_US 2
`define IPT_IDLE_LOWPWR_US 450

`endif

//--- src/ipt_pkg.sv
// Types of the primary two-wire target port.
// Assumes nothing of its surroundings.
package ipt_pkg;

  // Link-side protocol states
  typedef enum logic [5:0] {
    LS_IDLE   = 6'h01,
    LS_RXADDR = 6'h02,
    LS_RXBYTE = 6'h04,
    LS_ACKOUT = 6'h08,
    LS_TXBYTE = 6'h10,
    LS_ACKIN  = 6'h20
  } ipt_link_state_t;

  // Requests passed from the link to the register side
  typedef enum logic [1:0] {
    RK_SETADDR = 2'h0,
    RK_WRITE   = 2'h1,
    RK_READ    = 2'h2,
    RK_NEXT    = 2'h3
  } ipt_req_kind_t;

endpackage

//--- src/ipt_i2c_target.sv
// Primary two-wire target port: bus protocol on linkClk, register access
// and lock-up watchdog on mclk.
// Assumes pins pass through open-drain pads, and that the register file
// answers reads and trap lookups combinationally on regAddr.
`timescale 1ns/1ps
`include "ipt_defines.svh"

module ipt_i2c_target #(
  parameter int WDT_LONG_CYC =
    (`IPT_WDT_LONG_US * `IPT_MCLK_KHZ) / 1000
) (
  // Clocks and reset
  input  wire logic       mclk,
  input  wire logic       linkClk,
  input  wire logic       rst_n,
  // Two-wire pins
  input  wire logic       primaryClockPin,
  input  wire logic       primaryDataPinIn,
  output logic            primaryDataPinOut,
  output logic            primaryDataPinOeN,
  input  wire logic       addrSelPin,
  // Device state
  input  wire logic       spiSelected,
  input  wire logic       lockupTimerPeriodSelect,
  // Register file
  output logic [7:0]      regAddr,
  output logic [7:0]      regWrData,
  output logic            regWrEn,
  output logic            regRdEn,
  input  wire logic [7:0] regRdData,
  input  wire logic       regTrap
);

  localparam logic [`IPT_WDT_CNT_W-1:0] WDT_SHORT =
    `IPT_WDT_CNT_W'(`IPT_WDT_SHORT_CYC);
  localparam logic [`IPT_WDT_CNT_W-1:0] WDT_LONG =
    `IPT_WDT_CNT_W'(WDT_LONG_CYC);

  // mclk-domain state
  logic                      rstA;
  logic                      rstN;
  logic [1:0]                mMeta;
  logic [1:0]                mSync;
  logic                      reqSeen;
  logic [7:0]                startAddr;
  logic                      rspTgl;
  logic [7:0]                rspByte;
  logic [`IPT_WDT_CNT_W-1:0] wdtCnt;
  logic                      wdtAbort;
  logic                      reqEdge;
  logic                      lowM;

  // Link-domain state
  logic                      lrstA;
  logic                      lrstN;
  logic [5:0]                lMeta;
  logic [5:0]                lSync;
  logic                      sclPrev;
  logic                      sdaPrev;
  ipt_pkg::ipt_link_state_t  state;
  logic [3:0]                bitCnt;
  logic [7:0]                rxShift;
  logic [7:0]                txByte;
  logic                      isRead;
  logic                      firstByte;
  logic                      sawLow;
  logic                      ackOk;
  logic                      dataOeN;
  logic                      reqTgl;
  ipt_pkg::ipt_req_kind_t    reqKind;
  logic [7:0]                reqByte;
  logic                      rspSeen;

  // Named views of the synchronised link inputs
  logic sclQ;
  logic sdaQ;
  logic selQ;
  logic spiQ;
  logic abortQ;
  logic rspQ;
  logic sclRise;
  logic sclFall;
  logic startSeen;
  logic stopSeen;
  logic [6:0] myAddr;

  // Matched target address for the current strap level
  function automatic logic [6:0] target_addr(input logic sel);
    target_addr = sel ? `IPT_ADDR_HIGH : `IPT_ADDR_LOW; // see RULE_01 RULE_02
  endfunction

  // mclk domain

  // Reset release for mclk; assertion stays asynchronous
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rstA <= 1'b0;
      rstN <= 1'b0;
    end else begin
      rstA <= 1'b1;
      rstN <= rstA;
    end
  end

  // Request toggle and data-line drive level brought into mclk
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      mMeta <= 2'h1;
      mSync <= 2'h1;
    end else begin
      mMeta <= {reqTgl, dataOeN};
      mSync <= mMeta;
    end
  end

  assign reqEdge = mSync[1] ^ reqSeen;
  assign lowM    = ~mSync[0];

  // Register access. Link requests are a byte time apart, far longer than
  // the crossing, so request fields are stable when the toggle lands.
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      reqSeen   <= 1'b0;
      regAddr   <= `IPT_START_RST;
      startAddr <= `IPT_START_RST; // see RULE_14
      regWrData <= 8'h00;
      regWrEn   <= 1'b0;
      regRdEn   <= 1'b0;
      rspTgl    <= 1'b0;
      rspByte   <= 8'h00;
    end else begin
      regWrEn <= 1'b0;
      regRdEn <= 1'b0;
      if (reqEdge) begin
        reqSeen <= mSync[1];
        unique case (reqKind)
          ipt_pkg::RK_SETADDR: begin
            regAddr   <= reqByte;
            startAddr <= reqByte; // see RULE_14
          end
          ipt_pkg::RK_WRITE: begin
            regWrData <= reqByte; // see RULE_09
            regWrEn   <= 1'b1;
          end
          ipt_pkg::RK_READ: begin
            regAddr <= startAddr; // see RULE_14
            regRdEn <= 1'b1;
          end
          ipt_pkg::RK_NEXT: begin
            regRdEn <= 1'b1;
          end
        endcase
      end else if (regWrEn) begin
        // Trapping registers keep their address for the next byte
        if (!regTrap) begin
          regAddr <= regAddr + 8'h01; // see RULE_10
        end
      end else if (regRdEn) begin
        rspByte <= regRdData;
        rspTgl  <= ~rspTgl;
        regAddr <= regAddr + 8'h01; // see RULE_13
      end
    end
  end

  // Lock-up watchdog: counts while the port holds the data line low
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      wdtCnt   <= '0;
      wdtAbort <= 1'b0;
    end else if (!lowM) begin
      wdtCnt   <= '0; // see RULE_15
      wdtAbort <= 1'b0;
    end else if (wdtCnt ==
                 (lockupTimerPeriodSelect ? WDT_LONG : WDT_SHORT)) begin
      wdtAbort <= 1'b1; // see RULE_15 RULE_16
    end else begin
      wdtCnt <= wdtCnt + `IPT_WDT_CNT_W'(1);
    end
  end

  // Link domain

  // Reset release for linkClk
  always_ff @(posedge linkClk or negedge rst_n) begin
    if (!rst_n) begin
      lrstA <= 1'b0;
      lrstN <= 1'b0;
    end else begin
      lrstA <= 1'b1;
      lrstN <= lrstA;
    end
  end

  // Two-stage synchronisers; oversampling at linkClk keeps up with a
  // 1 MHz serial clock whose high phase spans several samples
  always_ff @(posedge linkClk or negedge lrstN) begin
    if (!lrstN) begin
      lMeta <= `IPT_SYNC_RST;
      lSync <= `IPT_SYNC_RST;
    end else begin
      lMeta <= {rspTgl, wdtAbort, spiSelected, addrSelPin,
                primaryDataPinIn, primaryClockPin}; // see RULE_04
      lSync <= lMeta;
    end
  end

  assign sclQ   = lSync[0];
  assign sdaQ   = lSync[1];
  assign selQ   = lSync[2];
  assign spiQ   = lSync[3];
  assign abortQ = lSync[4];
  assign rspQ   = lSync[5];

  // Previous samples for edge detection
  always_ff @(posedge linkClk or negedge lrstN) begin
    if (!lrstN) begin
      sclPrev <= 1'b1;
      sdaPrev <= 1'b1;
    end else begin
      sclPrev <= sclQ;
      sdaPrev <= sdaQ;
    end
  end

  assign sclRise   = sclQ & ~sclPrev;
  assign sclFall   = ~sclQ & sclPrev;
  assign startSeen = sclQ & sclPrev & sdaPrev & ~sdaQ; // see RULE_05
  assign stopSeen  = sclQ & sclPrev & ~sdaPrev & sdaQ; // see RULE_06
  assign myAddr    = target_addr(selQ);

  // Protocol engine: sample on clock rise, change the data line on fall
  always_ff @(posedge linkClk or negedge lrstN) begin
    if (!lrstN) begin
      state     <= ipt_pkg::LS_IDLE; // see RULE_19
      bitCnt    <= 4'h0;
      rxShift   <= 8'h00;
      txByte    <= 8'h00;
      isRead    <= 1'b0;
      firstByte <= 1'b0;
      sawLow    <= 1'b0;
      ackOk     <= 1'b0;
      dataOeN   <= 1'b1;
      reqTgl    <= 1'b0;
      reqKind   <= ipt_pkg::RK_SETADDR;
      reqByte   <= 8'h00;
      rspSeen   <= 1'b0;
    end else begin
      // Read data returned from the register side
      if (rspQ != rspSeen) begin
        rspSeen <= rspQ;
        txByte  <= rspByte;
      end
      if (abortQ || spiQ) begin
        // Watchdog expiry or SPI selection drops the transaction
        state   <= ipt_pkg::LS_IDLE; // see RULE_15 RULE_19
        dataOeN <= 1'b1;
      end else if (startSeen) begin
        // Start and repeated start both reopen address reception
        state   <= ipt_pkg::LS_RXADDR; // see RULE_05 RULE_11
        bitCnt  <= 4'h0;
        sawLow  <= 1'b0;
        dataOeN <= 1'b1;
      end else if (stopSeen && sawLow) begin
        // A stop with no clock low since the start is not honoured
        state   <= ipt_pkg::LS_IDLE; // see RULE_06 RULE_08
        dataOeN <= 1'b1;
      end else begin
        if (sclFall) begin
          sawLow <= 1'b1; // see RULE_08
        end
        unique case (state)
          ipt_pkg::LS_IDLE: begin
            dataOeN <= 1'b1;
          end
          ipt_pkg::LS_RXADDR, ipt_pkg::LS_RXBYTE: begin
            if (sclRise && bitCnt != `IPT_BYTE_BITS) begin
              rxShift <= {rxShift[6:0], sdaQ};
              bitCnt  <= bitCnt + 4'h1;
            end else if (sclFall && bitCnt == `IPT_BYTE_BITS) begin
              bitCnt <= 4'h0;
              if (state == ipt_pkg::LS_RXBYTE) begin
                // Register address first, then data bytes
                dataOeN   <= 1'b0; // see RULE_07 RULE_09
                state     <= ipt_pkg::LS_ACKOUT;
                firstByte <= 1'b0;
                reqKind   <= firstByte ? ipt_pkg::RK_SETADDR
                                       : ipt_pkg::RK_WRITE;
                reqByte   <= rxShift;
                reqTgl    <= ~reqTgl;
              end else if (rxShift[7:1] == myAddr) begin
                // Seven-bit compare only: ten-bit headers never match
                dataOeN   <= 1'b0; // see RULE_03 RULE_07
                state     <= ipt_pkg::LS_ACKOUT;
                isRead    <= rxShift[0];
                firstByte <= ~rxShift[0];
                if (rxShift[0]) begin
                  reqKind <= ipt_pkg::RK_READ; // see RULE_11 RULE_14
                  reqTgl  <= ~reqTgl;
                end
              end else begin
                state <= ipt_pkg::LS_IDLE; // see RULE_20
              end
            end
          end
          ipt_pkg::LS_ACKOUT: begin
            // Hold the ack through the high phase; on fall release it, or on a read drive the first data bit
            if (sclFall) begin
              if (isRead) begin
                dataOeN <= txByte[7]; // see RULE_11
                bitCnt  <= 4'h1;
                state   <= ipt_pkg::LS_TXBYTE;
              end else begin
                dataOeN <= 1'b1; // see RULE_07
                state   <= ipt_pkg::LS_RXBYTE;
              end
            end
          end
          ipt_pkg::LS_TXBYTE: begin
            if (sclFall) begin
              if (bitCnt == `IPT_BYTE_BITS) begin
                dataOeN <= 1'b1; // see RULE_07
                state   <= ipt_pkg::LS_ACKIN;
              end else begin
                dataOeN <= txByte[3'(4'h7 - bitCnt)];
                bitCnt  <= bitCnt + 4'h1;
              end
            end
          end
          ipt_pkg::LS_ACKIN: begin
            if (sclRise) begin
              ackOk <= ~sdaQ;
              if (!sdaQ) begin
                reqKind <= ipt_pkg::RK_NEXT; // see RULE_12 RULE_13
                reqTgl  <= ~reqTgl;
              end
            end else if (sclFall) begin
              if (ackOk) begin
                dataOeN <= txByte[7];
                bitCnt  <= 4'h1;
                state   <= ipt_pkg::LS_TXBYTE;
              end else begin
                // Nack: leave the line free for the master's stop
                dataOeN <= 1'b1; // see RULE_12
                state   <= ipt_pkg::LS_IDLE;
              end
            end
          end
          default: begin
            dataOeN <= 1'b1;
            state   <= ipt_pkg::LS_IDLE;
          end
        endcase
      end
    end
  end

  // Open-drain pad: the port only ever pulls low
  assign primaryDataPinOut = 1'b0;
  assign primaryDataPinOeN = dataOeN;

endmodule

//--- bench/ipt_i2c_target_sva.sv
// Assertion checker for the primary two-wire target port.
// Assumes it is bound to the port module and sees only its ports.
`timescale 1ns/1ps

module ipt_i2c_target_sva #(
  parameter int WDT_LONG_CYC = 1000000
) (
  // Clock and reset
  input wire logic       mclk,
  input wire logic       rst_n,
  // Pins and device state
  input wire logic       primaryDataPinOut,
  input wire logic       primaryDataPinOeN,
  input wire logic       spiSelected,
  input wire logic       lockupTimerPeriodSelect,
  // Register side
  input wire logic [7:0] regAddr,
  input wire logic       regWrEn,
  input wire logic       regRdEn,
  input wire logic       regTrap
);
  localparam int SHORT_CYC = 1250;  // 50 us of mclk
  localparam int SLACK     = 64;    // Sync and abort latency
  int lowCnt;

  // Counts how long the device has held the data line low
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lowCnt <= 0;
    end else begin
      lowCnt <= primaryDataPinOeN ? 0 : lowCnt + 1;
    end
  end

  default clocking dcb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  property p_wr_pulse;
    regWrEn |=> !regWrEn;
  endproperty
  a_wr_pulse: assert property (p_wr_pulse)
    else $error("write strobe longer than one cycle");
  property p_rd_pulse;
    regRdEn |=> !regRdEn;
  endproperty
  a_rd_pulse: assert property (p_rd_pulse)
    else $error("read strobe longer than one cycle");
  property p_one_access;
    !(regWrEn && regRdEn);
  endproperty
  a_one_access: assert property (p_one_access)
    else $error("read and write strobes together");
  property p_wr_step;
    regWrEn && !regTrap |=> regAddr == $past(regAddr) + 8'h01;
  endproperty
  a_wr_step: assert property (p_wr_step)
    else $error("pointer did not advance after write");
  property p_wr_trap;
    regWrEn && regTrap |=> $stable(regAddr);
  endproperty
  a_wr_trap: assert property (p_wr_trap)
    else $error("pointer moved on trapping register");
  property p_rd_step;
    regRdEn |=> regAddr == $past(regAddr) + 8'h01;
  endproperty
  a_rd_step: assert property (p_rd_step)
    else $error("pointer did not advance after read");
  property p_open_drain;
    primaryDataPinOut == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("data pin driven high");
  property p_wdt;
    lowCnt <= (lockupTimerPeriodSelect ? WDT_LONG_CYC : SHORT_CYC) + SLACK;
  endproperty
  a_wdt: assert property (p_wdt)
    else $error("data line held low past watchdog period");
  property p_spi_quiet;
    spiSelected [*8] |-> primaryDataPinOeN;
  endproperty
  a_spi_quiet: assert property (p_spi_quiet)
    else $error("data line pulled while port deselected");
endmodule

bind ipt_i2c_target ipt_i2c_target_sva #(.WDT_LONG_CYC(WDT_LONG_CYC)) u_sva (
  .mclk(mclk), .rst_n(rst_n), .primaryDataPinOut(primaryDataPinOut),
  .primaryDataPinOeN(primaryDataPinOeN), .spiSelected(spiSelected),
  .lockupTimerPeriodSelect(lockupTimerPeriodSelect), .regAddr(regAddr),
  .regWrEn(regWrEn), .regRdEn(regRdEn), .regTrap(regTrap)
);

//--- bench/ipt_master_model.sv
// Two-wire bus master model at 1 MHz driving clock and data lines.
// Assumes the bench resolves the data wire with a pull-up.
`timescale 1ns/1ps

module ipt_master_model (
  // Resolved data wire
  input  wire logic sdaWire,
  // Master drive, high means released
  output logic      sclOut,
  output logic      sdaOut
);
  localparam int Q = 250;  // Quarter of a 1 us bit

  // Bus idles released
  initial begin
    sclOut = 1'b1;
    sdaOut = 1'b1;
  end

  // Start or repeated start: data falls while clock high
  task automatic start_cond();
    sdaOut = 1'b1;
    #Q sclOut = 1'b1;
    #Q sdaOut = 1'b0;
    #Q sclOut = 1'b0;
  endtask

  // Stop: data rises while clock high
  task automatic stop_cond();
    #Q sdaOut = 1'b0;
    #Q sclOut = 1'b1;
    #Q sdaOut = 1'b1;
    #Q;
  endtask

  // One bit: data set while clock low, sampled while high
  task automatic bit_xfer(input logic b, output logic s);
    #Q sdaOut = b;
    #Q sclOut = 1'b1;
    #Q s = sdaWire;
    #Q sclOut = 1'b0;
  endtask

  // Byte MSB first, then the ack bit; reads send 8'hFF to release
  task automatic xfer_byte(input logic [7:0] d, input logic ackIn,
                           output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(d[i], q[i]);
    end
    bit_xfer(ackIn, ack);
  endtask
endmodule

//--- bench/imu_primary_i2c_target_tb.sv
// Self-checking bench for the primary two-wire target port.
// Assumes the master model and the checker are compiled alongside.
`timescale 1ns/1ps

module imu_primary_i2c_target_tb;
  localparam int         LONG_CYC = 2000;   // Shortened long watchdog
  localparam logic [7:0] TRAP     = 8'h5E;  // Trapping register of the model
  localparam logic [6:0] ADDR_LO  = 7'h68;
  localparam logic [6:0] ADDR_HI  = 7'h69;
  logic        mclk        = 1'b0;
  logic        linkClk     = 1'b0;
  logic        rst_n       = 1'b0;
  logic        addrSelPin  = 1'b0;
  logic        spiSelected = 1'b0;
  logic        wdtSel      = 1'b0;
  logic        sclOut, sdaOut, sdaWire, pinOut, pinOeN;
  logic [7:0]  regAddr, regWrData, regRdData, startAddr;
  logic        regWrEn, regRdEn, regTrap;
  logic [7:0]  mem [256];
  logic [16:0] expQ [$];
  logic [16:0] expN, accN;
  int          mismatches = 0;
  int          compares   = 0;
  int          seed       = 32'h2797;

  // Unrelated clocks: 40 ns core, 48 ns link
  always #20 mclk = ~mclk;
  always #24 linkClk = ~linkClk;

  // Open-drain wire with pull-up: released reads high
  assign sdaWire = sdaOut & (pinOeN | pinOut);
  assign regRdData = mem[regAddr];
  assign regTrap = (regAddr == TRAP);

  ipt_i2c_target #(.WDT_LONG_CYC(LONG_CYC)) u_dut (
    .mclk(mclk), .linkClk(linkClk), .rst_n(rst_n),
    .primaryClockPin(sclOut), .primaryDataPinIn(sdaWire),
    .primaryDataPinOut(pinOut), .primaryDataPinOeN(pinOeN),
    .addrSelPin(addrSelPin), .spiSelected(spiSelected),
    .lockupTimerPeriodSelect(wdtSel), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regRdData(regRdData), .regTrap(regTrap)
  );
  ipt_master_model u_master (
    .sdaWire(sdaWire), .sclOut(sclOut), .sdaOut(sdaOut)
  );

  task automatic chk(string what, logic [16:0] e, logic [16:0] s);
    compares++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH %s: expected %h, seen %h", what, e, s);
    end
  endtask

  // Register file model; each access takes the oldest note off the queue
  always @(posedge mclk) begin
    if (regWrEn) mem[regAddr] <= regWrData;
    if (regWrEn || regRdEn) begin
      expN = (expQ.size() > 0) ? expQ.pop_front() : 17'h1FFFF;
      accN = {regWrEn, regAddr, regWrEn ? regWrData : regRdData};
      chk("access", expN, accN);
    end
  end

  // Pointer then n data bytes, all acknowledged
  task automatic do_write(logic [6:0] dev, logic [7:0] ra, int n);
    logic [7:0] q, d, a;
    logic       ack;
    a = ra;
    startAddr = ra;
    u_master.start_cond();
    u_master.xfer_byte({dev, 1'b0}, 1'b1, q, ack);
    chk("addr ack", 17'h0, 17'(ack));
    u_master.xfer_byte(ra, 1'b1, q, ack);
    chk("reg ack", 17'h0, 17'(ack));
    for (int i = 0; i < n; i++) begin
      d = 8'($random(seed));
      expQ.push_back({1'b1, a, d});
      u_master.xfer_byte(d, 1'b1, q, ack);
      chk("data ack", 17'h0, 17'(ack));
      if (a != TRAP) a++;
    end
    u_master.stop_cond();
    #2000;
  endtask

  // Optional pointer write, repeated start, n bytes ending with a nack
  task automatic do_read(logic setPtr, logic [7:0] ra, int n);
    logic [7:0] q, a;
    logic       ack;
    if (setPtr) begin
      u_master.start_cond();
      u_master.xfer_byte({ADDR_LO, 1'b0}, 1'b1, q, ack);
      u_master.xfer_byte(ra, 1'b1, q, ack);
      startAddr = ra;
    end
    a = startAddr;
    for (int i = 0; i < n; i++) begin
      expQ.push_back({1'b0, a, mem[a]});
      a++;
    end
    u_master.start_cond();
    u_master.xfer_byte({ADDR_LO, 1'b1}, 1'b1, q, ack);
    chk("read addr ack", 17'h0, 17'(ack));
    a = startAddr;
    for (int i = 0; i < n; i++) begin
      u_master.xfer_byte(8'hFF, i == n - 1, q, ack);
      chk("read data", {9'h0, mem[a]}, {9'h0, q});
      a++;
    end
    // Give the port time to react to the nack before looking
    #300;
    chk("released", 17'h1, 17'(pinOeN));
    u_master.stop_cond();
  endtask

  // Address byte that must be left unanswered, then a byte ignored
  task automatic do_reject(logic [6:0] dev);
    logic [7:0] q;
    logic       ack;
    u_master.start_cond();
    u_master.xfer_byte({dev, 1'b0}, 1'b1, q, ack);
    chk("foreign addr", 17'h1, 17'(ack));
    u_master.xfer_byte(8'h41, 1'b1, q, ack);
    chk("ignored byte", 17'h1, 17'(ack));
    u_master.stop_cond();
  endtask

  // Master stalls the clock while the device target_acknowledge the address
  task automatic do_wdt(logic sel, int cyc);
    logic b;
    @(posedge mclk) #1 wdtSel = sel;
    u_master.start_cond();
    for (int i = 7; i >= 0; i--) begin
      u_master.bit_xfer(ADDR_LO[i > 0 ? i - 1 : 0] & (i > 0), b);
    end
    repeat (cyc - 100) @(posedge mclk);
    chk("lockup hold", 17'h0, 17'(pinOeN));
    repeat (200) @(posedge mclk);
    chk("lockup free", 17'h1, 17'(pinOeN));
    u_master.stop_cond();
  endtask

  task automatic final_report();
    chk("pending", 17'h0, 17'(expQ.size()));
    $display("Compares %0d, mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    startAddr = 8'h00;
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'hA5;
    repeat (2) @(posedge mclk);
    #1 rst_n = 1'b1;
    repeat (10) @(posedge mclk);
    do_read(1'b0, 8'h00, 1);
    do_write(ADDR_LO, 8'h41, 2);
    do_write(ADDR_LO, TRAP, 3);
    do_read(1'b1, 8'hFE, 3);
    do_read(1'b0, 8'h00, 2);
    do_reject(ADDR_HI);
    @(posedge mclk) #1 addrSelPin = 1'b1;
    do_reject(ADDR_LO);
    do_write(ADDR_HI, 8'h20, 1);
    @(posedge mclk) #1 addrSelPin = 1'b0;
    spiSelected = 1'b1;
    do_reject(ADDR_LO);
    @(posedge mclk) #1 spiSelected = 1'b0;
    do_wdt(1'b0, 1250);
    do_wdt(1'b1, LONG_CYC);
    do_write(ADDR_LO, 8'h30, 1);
    // Low-power idle after the write, then read the byte back
    #448000;
    do_read(1'b0, 8'h00, 1);
    final_report();
  end

  // Watchdog on the whole run
  initial begin
    #2000000;
    mismatches++;
    final_report();
  end
endmodule
